// ==== verilog/ldo_pkg.sv ====
// constants, register layouts and types for the regulator control bank
`default_nettype none
package ldo_pkg;

	// ****************************************************************
	// register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [15:0] IDX_A_ON_CTRL    = 16'h406F;
	localparam logic [15:0] IDX_A_SLEEP_CTRL = 16'h4070;
	localparam logic [15:0] IDX_B_CTRL       = 16'h4071;
	localparam logic [15:0] IDX_B_ON_CTRL    = 16'h4072;
	localparam logic [15:0] IDX_B_SLEEP_CTRL = 16'h4073;
	localparam logic [15:0] IDX_IRQ_STATUS   = 16'h4080;
	localparam logic [15:0] IDX_IRQ_ENABLE   = 16'h4081;
	localparam int          ADDR_W           = 18;

	// ****************************************************************
	// field layouts
	// ****************************************************************
	typedef struct packed {
		logic [2:0] slot;
		logic [3:0] rsv_hi;
		logic       lowpower;
		logic [2:0] rsv_lo;
		logic [4:0] volt_code;
	} ldo_slot_ctrl_type;

	typedef struct packed {
		logic [1:0] undervolt_action;
		logic       rsv_13;
		logic [1:0] hwctl_source;
		logic       hwctl_volt_sel;
		logic [1:0] hwctl_opmode;
		logic       float_when_off;
		logic       switch_mode;
		logic [4:0] rsv_lo;
		logic       lowpower_variant;
	} ldo_b_ctrl_type;

	// bits that software may store; the rest read as zero
	localparam logic [15:0] SLOT_CTRL_WMASK = 16'hE11F;
	localparam logic [15:0] B_CTRL_WMASK    = 16'hDFC1;

	// ****************************************************************
	// values after reset
	// ****************************************************************
	localparam logic [15:0] RST_A_ON_CTRL    = 16'h0000;
	localparam logic [15:0] RST_A_SLEEP_CTRL = 16'h0100;
	localparam logic [15:0] RST_B_CTRL       = 16'h0200;
	localparam logic [15:0] RST_B_ON_CTRL    = 16'h0000;
	localparam logic [15:0] RST_B_SLEEP_CTRL = 16'h0100;
	localparam logic [1:0]  RST_IRQ          = 2'h0;

	// ****************************************************************
	// encodings
	// ****************************************************************
	localparam logic [2:0] ON_SLOT_OFF  = 3'h0;
	localparam logic [2:0] ON_SLOT_HW1  = 3'h6;
	localparam logic [2:0] ON_SLOT_HW2  = 3'h7;
	localparam logic [2:0] SLP_DIS_LO   = 3'h1;
	localparam logic [2:0] SLP_DIS_HI   = 3'h5;
	localparam logic [1:0] UV_SHUT_REG  = 2'h1;
	localparam logic [1:0] UV_SHUT_SYS  = 2'h2;
	localparam logic [1:0] HW_SRC_1     = 2'h1;
	localparam logic [1:0] HW_SRC_2     = 2'h2;
	localparam logic [1:0] HW_SRC_EITHER = 2'h3;
	localparam logic [1:0] HW_MODE_OFF  = 2'h1;
	localparam logic [1:0] HW_MODE_ON   = 2'h3;
	localparam int         IRQ_UV_B     = 0;
	localparam int         IRQ_SLEEP_A  = 1;
	localparam int         IRQ_W        = 2;

	// ****************************************************************
	// voltage code scale in millivolts, millivolt width and synchroniser depth
	// ****************************************************************
	localparam logic [4:0] VCODE_SPLIT = 5'h0F;
	localparam int         VLO_BASE_MV = 900;
	localparam int         VLO_STEP_MV = 50;
	localparam int         VHI_BASE_MV = 1700;
	localparam int         VHI_STEP_MV = 100;
	localparam int         MV_W        = 12;
	localparam int         SYNC_STAGES = 3;

endpackage
`default_nettype wire

// ==== verilog/ldo_volt_decode.sv ====
// voltage select code to output millivolts
`timescale 1ns/1ps
`default_nettype none

module ldo_volt_decode (
	input  wire logic [4:0]                code,
	output logic      [ldo_pkg::MV_W-1:0] millivolts
);
	import ldo_pkg::*;

	// ****************************************************************
	// two linear segments
	// ****************************************************************
	always_comb begin
		if (code < VCODE_SPLIT) begin
			millivolts = MV_W'(VLO_BASE_MV + VLO_STEP_MV * int'(code));
		end else begin
			millivolts = MV_W'(VHI_BASE_MV + VHI_STEP_MV * (int'(code) - int'(VCODE_SPLIT)));
		end
	end

endmodule
`default_nettype wire

// ==== verilog/ldo_regs.sv ====
// apb register bank and output logic for two linear regulators
`timescale 1ns/1ps
`default_nettype none

module ldo_regs (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	input  wire logic [ldo_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        hw_enable_1,
	input  wire logic                        hw_enable_2,
	input  wire logic                        reg_b_undervolt,
	input  wire logic                        sleep_entry,
	input  wire logic [2:0]                  sleep_timeslot,
	output logic                             reg_a_en,
	output logic                             reg_a_lowpower,
	output logic      [ldo_pkg::MV_W-1:0]    reg_a_volt_mv,
	output logic                             reg_b_en,
	output logic                             reg_b_lowpower,
	output logic                             reg_b_lp_min_quiescent,
	output logic                             reg_b_discharge,
	output logic                             reg_b_switch_mode,
	output logic      [ldo_pkg::MV_W-1:0]    reg_b_volt_mv,
	output logic                             sys_reset_req,
	output logic                             irq
);
	import ldo_pkg::*;

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		hits = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
	endfunction

	// sleep slot code to the timeslot in which it acts
	function automatic logic [2:0] sleep_slot_of(input logic [2:0] code);
		case (code)
			3'h0: sleep_slot_of = 3'h5;
			3'h1: sleep_slot_of = 3'h5;
			3'h2: sleep_slot_of = 3'h4;
			3'h3: sleep_slot_of = 3'h3;
			3'h4: sleep_slot_of = 3'h2;
			3'h5: sleep_slot_of = 3'h1;
			3'h6: sleep_slot_of = 3'h3;
			default: sleep_slot_of = 3'h1;
		endcase
	endfunction

	function automatic logic on_pin_level(input logic [2:0] slot, input logic p1, input logic p2);
		case (slot)
			ON_SLOT_OFF: on_pin_level = 1'b0;
			ON_SLOT_HW1: on_pin_level = p1;
			ON_SLOT_HW2: on_pin_level = p2;
			default:     on_pin_level = 1'b1;
		endcase
	endfunction

	// ****************************************************************
	// storage
	// ****************************************************************
	ldo_slot_ctrl_type a_on;
	ldo_slot_ctrl_type a_sleep;
	ldo_b_ctrl_type    b_ctrl;
	ldo_slot_ctrl_type b_on;
	ldo_slot_ctrl_type b_sleep;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_enable;

	logic              setup;
	logic              access;
	logic              wr_done;
	logic              rd_done;
	logic [15:0]       wdata16;
	logic [15:0]       next_rdata;
	logic              next_err;

	assign setup   = ce && psel && !penable;
	assign access  = ce && psel && penable;
	assign pready  = ce;
	assign wr_done = access && pwrite && !pslverr;
	assign rd_done = access && !pwrite && !pslverr;
	assign wdata16 = pwdata[15:0];

	always_comb begin
		next_rdata = 16'h0000;
		next_err   = 1'b0;
		if (hits(paddr, IDX_A_ON_CTRL)) begin
			next_rdata = a_on;
		end else if (hits(paddr, IDX_A_SLEEP_CTRL)) begin
			next_rdata = a_sleep;
		end else if (hits(paddr, IDX_B_CTRL)) begin
			next_rdata = b_ctrl;
		end else if (hits(paddr, IDX_B_ON_CTRL)) begin
			next_rdata = b_on;
		end else if (hits(paddr, IDX_B_SLEEP_CTRL)) begin
			next_rdata = b_sleep;
		end else if (hits(paddr, IDX_IRQ_STATUS)) begin
			next_rdata = {14'h0000, irq_status};
		end else if (hits(paddr, IDX_IRQ_ENABLE)) begin
			next_rdata = {14'h0000, irq_enable};
		end else begin
			next_err = 1'b1;
		end
	end

	// ****************************************************************
	// apb answer, captured in the setup cycle so data leaves a flop
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, next_rdata};
			pslverr <= next_err;
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_on    <= RST_A_ON_CTRL;
			a_sleep <= RST_A_SLEEP_CTRL;
			b_ctrl  <= RST_B_CTRL;
			b_on    <= RST_B_ON_CTRL;
			b_sleep <= RST_B_SLEEP_CTRL;
		end else if (wr_done) begin
			if (hits(paddr, IDX_A_ON_CTRL)) begin
				a_on <= wdata16 & SLOT_CTRL_WMASK;
			end
			if (hits(paddr, IDX_A_SLEEP_CTRL)) begin
				a_sleep <= wdata16 & SLOT_CTRL_WMASK;
			end
			if (hits(paddr, IDX_B_CTRL)) begin
				b_ctrl <= wdata16 & B_CTRL_WMASK;
			end
			if (hits(paddr, IDX_B_ON_CTRL)) begin
				b_on <= wdata16 & SLOT_CTRL_WMASK;
			end
			if (hits(paddr, IDX_B_SLEEP_CTRL)) begin
				b_sleep <= wdata16 & SLOT_CTRL_WMASK;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= RST_IRQ;
		end else if (wr_done && hits(paddr, IDX_IRQ_ENABLE)) begin
			irq_enable <= wdata16[IRQ_W-1:0];
		end
	end

	// ****************************************************************
	// pin synchronisers, accepted once stages two and three agree
	// ****************************************************************
	localparam int NPIN = 3;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_ok;
	assign pin_raw = {reg_b_undervolt, hw_enable_2, hw_enable_1};

	generate
		for (genvar i = 0; i < NPIN; i++) begin : g_sync
			logic [SYNC_STAGES-1:0] stage;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage     <= '0;
					pin_ok[i] <= 1'b0;
				end else if (ce) begin
					stage <= {stage[SYNC_STAGES-2:0], pin_raw[i]};
					if (stage[1] == stage[2]) begin
						pin_ok[i] <= stage[2];
					end
				end
			end
		end
	endgenerate

	logic hw1;
	logic hw2;
	logic uv_level;
	logic uv_prev;
	logic uv_event;
	assign hw1      = pin_ok[0];
	assign hw2      = pin_ok[1];
	assign uv_level = pin_ok[2];
	assign uv_event = uv_level && !uv_prev;

	// ****************************************************************
	// regulator a sleep sequencing
	// ****************************************************************
	logic a_hw_assigned;
	logic a_disable;
	logic a_hit;
	logic a_hit_prev;
	assign a_hw_assigned = (a_on.slot == ON_SLOT_HW1) || (a_on.slot == ON_SLOT_HW2);
	// disable codes become plain transitions under a hardware enable
	assign a_disable = (a_sleep.slot >= SLP_DIS_LO) && (a_sleep.slot <= SLP_DIS_HI)
		&& !a_hw_assigned;

	// once reached, the sleep condition holds until sleep is left
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_hit      <= 1'b0;
			a_hit_prev <= 1'b0;
		end else if (ce) begin
			a_hit_prev <= a_hit;
			if (!sleep_entry) begin
				a_hit <= 1'b0;
			end else if (sleep_timeslot == sleep_slot_of(a_sleep.slot)) begin
				a_hit <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// regulator b undervoltage handling
	// ****************************************************************
	logic b_shut;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_prev       <= 1'b0;
			b_shut        <= 1'b0;
			sys_reset_req <= 1'b0;
		end else if (ce) begin
			uv_prev       <= uv_level;
			sys_reset_req <= uv_event && (b_ctrl.undervolt_action == UV_SHUT_SYS);
			if (uv_event && (b_ctrl.undervolt_action == UV_SHUT_REG)) begin
				b_shut <= 1'b1;
			end else if (wr_done && hits(paddr, IDX_B_ON_CTRL)) begin
				b_shut <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// interrupt status: read clears, a new event wins
	// ****************************************************************
	logic [IRQ_W-1:0] irq_set;
	logic             status_rd;
	assign irq_set[IRQ_UV_B]    = uv_event;
	assign irq_set[IRQ_SLEEP_A] = a_hit && !a_hit_prev;
	assign status_rd            = rd_done && hits(paddr, IDX_IRQ_STATUS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= RST_IRQ;
		end else if (ce) begin
			// clear only the bits the reader was shown; later events survive
			irq_status <= (status_rd ? irq_status & ~prdata[IRQ_W-1:0] : irq_status) | irq_set;
		end
	end

	assign irq = |(irq_status & irq_enable);

	// ****************************************************************
	// regulator output selection
	// ****************************************************************
	logic       b_hw_asserted;
	logic       next_a_en;
	logic       next_a_lp;
	logic [4:0] next_a_code;
	logic       next_b_en;
	logic       next_b_lp;
	logic [4:0] next_b_code;
	logic [MV_W-1:0] a_mv;
	logic [MV_W-1:0] b_mv;

	always_comb begin
		case (b_ctrl.hwctl_source)
			HW_SRC_1:      b_hw_asserted = hw1;
			HW_SRC_2:      b_hw_asserted = hw2;
			HW_SRC_EITHER: b_hw_asserted = hw1 || hw2;
			default:       b_hw_asserted = 1'b0;
		endcase
	end

	always_comb begin
		next_a_en   = on_pin_level(a_on.slot, hw1, hw2);
		next_a_lp   = a_on.lowpower;
		next_a_code = a_on.volt_code;
		if (a_hit) begin
			if (a_disable) begin
				next_a_en = 1'b0;
			end else begin
				next_a_lp   = a_sleep.lowpower;
				next_a_code = a_sleep.volt_code;
			end
		end
	end

	always_comb begin
		next_b_en   = on_pin_level(b_on.slot, hw1, hw2) && !b_shut;
		next_b_lp   = b_on.lowpower;
		next_b_code = b_on.volt_code;
		if (b_hw_asserted) begin
			next_b_code = b_ctrl.hwctl_volt_sel ? b_sleep.volt_code : b_on.volt_code;
			case (b_ctrl.hwctl_opmode)
				HW_MODE_OFF: next_b_en = 1'b0;
				HW_MODE_ON:  next_b_lp = b_on.lowpower;
				default:     next_b_lp = 1'b1;
			endcase
		end
	end

	ldo_volt_decode u_a_volt (
		.code       (next_a_code),
		.millivolts (a_mv)
	);

	ldo_volt_decode u_b_volt (
		.code       (next_b_code),
		.millivolts (b_mv)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_a_en               <= 1'b0;
			reg_a_lowpower         <= 1'b0;
			reg_a_volt_mv          <= '0;
			reg_b_en               <= 1'b0;
			reg_b_lowpower         <= 1'b0;
			reg_b_lp_min_quiescent <= 1'b0;
			reg_b_discharge        <= 1'b0;
			reg_b_switch_mode      <= 1'b0;
			reg_b_volt_mv          <= '0;
		end else if (ce) begin
			reg_a_en               <= next_a_en;
			reg_a_lowpower         <= next_a_lp;
			reg_a_volt_mv          <= a_mv;
			reg_b_en               <= next_b_en;
			reg_b_lowpower         <= next_b_lp;
			reg_b_lp_min_quiescent <= next_b_lp && b_ctrl.lowpower_variant;
			reg_b_discharge        <= !next_b_en && !b_ctrl.float_when_off;
			reg_b_switch_mode      <= b_ctrl.switch_mode;
			reg_b_volt_mv          <= b_mv;
		end
	end

	// ****************************************************************
	// checks; they are disabled during reset and while ce is low
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	sleep_disable_a: assert property (a_hit && a_disable |=> !reg_a_en)
		else $error("regulator a not disabled in its sleep slot");
	sleep_mode_a: assert property (
		a_hit && !a_disable |=> reg_a_lowpower == $past(a_sleep.lowpower))
		else $error("regulator a sleep mode not applied");
	hw_sleep_a: assert property (
		a_hit && a_hw_assigned |=> reg_a_lowpower == $past(a_sleep.lowpower))
		else $error("hardware-enabled regulator a missed its sleep mode");
	slot_hit_a: assert property (
		sleep_entry && sleep_timeslot == 3'h3 && a_sleep.slot == 3'h6 |=> a_hit)
		else $error("sleep transition slot missed");
	// presetn in the antecedent: the edge that releases reset still loads reset values
	volt_low_a: assert property (
		presetn && next_b_code < 5'h0F
		|=> reg_b_volt_mv == MV_W'(900 + 50 * int'($past(next_b_code))))
		else $error("low voltage segment wrong");
	volt_high_a: assert property (
		presetn && next_b_code >= 5'h0F
		|=> reg_b_volt_mv == MV_W'(1700 + 100 * (int'($past(next_b_code)) - 15)))
		else $error("high voltage segment wrong");
	uv_irq_a: assert property (uv_event |=> irq_status[IRQ_UV_B])
		else $error("undervoltage interrupt not raised");
	uv_shut_a: assert property (
		uv_event && b_ctrl.undervolt_action == 2'h1 |-> ##2 !reg_b_en)
		else $error("undervoltage shutdown missing");
	hw_off_a: assert property (b_hw_asserted && b_ctrl.hwctl_opmode == 2'h1 |=> !reg_b_en)
		else $error("hardware off mode ignored");
	float_out_a: assert property (reg_b_discharge |-> !reg_b_en)
		else $error("discharge while enabled");
	variant_lp_a: assert property (reg_b_lp_min_quiescent |-> reg_b_lowpower)
		else $error("quiescent variant outside low power");

	cover property (uv_event ##1 irq);
	cover property (a_hit && a_disable ##1 !reg_a_en);
	cover property (b_hw_asserted && b_ctrl.hwctl_volt_sel);
	cover property (status_rd && irq_status != '0);

endmodule
`default_nettype wire

// ==== verif/test_ldo_sleep_and_control_regs.sv ====
// self-checking testbench for the regulator control register bank
`timescale 1ns/1ps
`default_nettype none

module test_ldo_sleep_and_control_regs;
	import ldo_pkg::*;

	logic                pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata, prdata;
	logic                hw_enable_1, hw_enable_2, reg_b_undervolt, sleep_entry;
	logic [2:0]          sleep_timeslot;
	logic                reg_a_en, reg_a_lowpower, reg_b_en, reg_b_lowpower;
	logic                reg_b_lp_min_quiescent, reg_b_discharge, reg_b_switch_mode;
	logic                sys_reset_req, irq;
	logic [MV_W-1:0]     reg_a_volt_mv, reg_b_volt_mv;
	int                  err_count, compares, cycles, resets_seen;

	ldo_regs ldo_regs_i (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hw_enable_1(hw_enable_1), .hw_enable_2(hw_enable_2),
		.reg_b_undervolt(reg_b_undervolt), .sleep_entry(sleep_entry),
		.sleep_timeslot(sleep_timeslot), .reg_a_en(reg_a_en), .reg_a_lowpower(reg_a_lowpower),
		.reg_a_volt_mv(reg_a_volt_mv), .reg_b_en(reg_b_en), .reg_b_lowpower(reg_b_lowpower),
		.reg_b_lp_min_quiescent(reg_b_lp_min_quiescent), .reg_b_discharge(reg_b_discharge),
		.reg_b_switch_mode(reg_b_switch_mode), .reg_b_volt_mv(reg_b_volt_mv),
		.sys_reset_req(sys_reset_req), .irq(irq));

	// ****************************************************************
	// clock, timeout and pulse counting
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (sys_reset_req === 1'b1)
			resets_seen++;
		// ceiling is about twenty times the expected run length
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic results;
		if (err_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// the wait ends at the first edge that sees pready high
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
		cyc(2);
	endtask

	task automatic rchk(input logic [15:0] idx, input logic [15:0] exp, input logic experr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 16'h0000, r, e);
		chk("prdata", {16'h0000, exp}, r);
		chk("pslverr", experr, e);
	endtask

	task automatic sleep_at(input logic [2:0] ts);
		@(posedge pclk);
		sleep_entry <= 1'b1;
		sleep_timeslot <= ts;
		cyc(4);
	endtask

	task automatic sleep_off;
		@(posedge pclk);
		sleep_entry <= 1'b0;
		cyc(4);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs;
		rchk(IDX_A_SLEEP_CTRL, 16'h0100, 1'b0);
		rchk(IDX_B_CTRL, 16'h0200, 1'b0);
		rchk(16'h4090, 16'h0000, 1'b1);
		wr(IDX_A_SLEEP_CTRL, 16'hFFFF);
		rchk(IDX_A_SLEEP_CTRL, 16'hE11F, 1'b0);
		wr(IDX_B_CTRL, 16'hFFFF);
		rchk(IDX_B_CTRL, 16'hDFC1, 1'b0);
		chk("reg_b_switch_mode", 1, reg_b_switch_mode);
		wr(IDX_B_CTRL, 16'h0000);
		chk("reg_b_switch_mode", 0, reg_b_switch_mode);
	endtask

	task automatic t_volt;
		int mv;
		wr(IDX_A_ON_CTRL, 16'h2000);
		for (int c = 0; c < 32; c++) begin
			wr(IDX_A_SLEEP_CTRL, 16'h0100 | 16'(c));
			mv = (c < 15) ? 900 + 50 * c : 1700 + 100 * (c - 15);
			sleep_at(3'h5);
			chk("reg_a_volt_mv", mv, reg_a_volt_mv);
			sleep_off();
		end
	endtask

	task automatic t_slot;
		logic [2:0] slot_of [8];
		slot_of = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};
		for (int c = 0; c < 8; c++) begin
			wr(IDX_A_SLEEP_CTRL, {3'(c), 13'h010A});
			sleep_at(3'h0);
			chk("reg_a_en", 1, reg_a_en);
			chk("reg_a_lowpower", 0, reg_a_lowpower);
			sleep_at(slot_of[c]);
			if (c == 0 || c > 5) begin
				chk("reg_a_en", 1, reg_a_en);
				chk("reg_a_lowpower", 1, reg_a_lowpower);
				chk("reg_a_volt_mv", 1400, reg_a_volt_mv);
			end else
				chk("reg_a_en", 0, reg_a_en);
			sleep_off();
			chk("reg_a_en", 1, reg_a_en);
		end
	endtask

	task automatic t_hw_a;
		wr(IDX_A_ON_CTRL, 16'hC000);
		cyc(6);
		chk("reg_a_en", 0, reg_a_en);
		hw_enable_1 <= 1'b1;
		cyc(6);
		chk("reg_a_en", 1, reg_a_en);
		wr(IDX_A_SLEEP_CTRL, 16'h610A);
		sleep_at(3'h5);
		chk("reg_a_volt_mv", 900, reg_a_volt_mv);
		sleep_at(3'h3);
		chk("reg_a_volt_mv", 1400, reg_a_volt_mv);
		sleep_off();
		hw_enable_1 <= 1'b0;
	endtask

	task automatic uv_pulse;
		@(posedge pclk);
		reg_b_undervolt <= 1'b1;
		cyc(8);
	endtask

	task automatic t_uv;
		logic [31:0] r;
		logic        e;
		wr(IDX_IRQ_ENABLE, 16'h0001);
		// earlier sleep hits left status bits set
		apb(1'b0, IDX_IRQ_STATUS, 16'h0000, r, e);
		for (int a = 0; a < 3; a++) begin
			wr(IDX_B_ON_CTRL, 16'h2000);
			wr(IDX_B_CTRL, 16'(a) << 14);
			resets_seen = 0;
			uv_pulse();
			chk("irq", 1, irq);
			chk("reg_b_en", a != 1, reg_b_en);
			chk("resets_seen", a == 2, resets_seen);
			rchk(IDX_IRQ_STATUS, 16'h0001, 1'b0);
			cyc(1);
			chk("irq", 0, irq);
			reg_b_undervolt <= 1'b0;
			cyc(4);
		end
		wr(IDX_IRQ_ENABLE, 16'h0000);
		uv_pulse();
		chk("irq", 0, irq);
		rchk(IDX_IRQ_STATUS, 16'h0001, 1'b0);
		reg_b_undervolt <= 1'b0;
	endtask

	task automatic t_hw_b;
		logic under;
		wr(IDX_B_ON_CTRL, 16'h2002);
		wr(IDX_B_SLEEP_CTRL, 16'h001F);
		for (int i = 0; i < 8; i++) begin
			hw_enable_1 <= (i < 4);
			hw_enable_2 <= (i >= 4);
			under = (i % 4 == 3) || (i == 1) || (i == 6);
			// second half uses hardware mode 10, the other low-power code
			wr(IDX_B_CTRL, (16'(i % 4) << 11) | (i >= 4 ? 16'h0601 : 16'h0401));
			cyc(6);
			chk("reg_b_volt_mv", under ? 3300 : 1000, reg_b_volt_mv);
			chk("reg_b_lowpower", under, reg_b_lowpower);
			chk("reg_b_lp_min_quiescent", under, reg_b_lp_min_quiescent);
		end
		hw_enable_1 <= 1'b1;
		hw_enable_2 <= 1'b0;
		wr(IDX_B_CTRL, 16'h0900);
		cyc(6);
		chk("reg_b_en", 0, reg_b_en);
		chk("reg_b_discharge", 1, reg_b_discharge);
		wr(IDX_B_CTRL, 16'h0980);
		chk("reg_b_discharge", 0, reg_b_discharge);
		wr(IDX_B_CTRL, 16'h0B00);
		chk("reg_b_lowpower", 0, reg_b_lowpower);
		chk("reg_b_volt_mv", 1000, reg_b_volt_mv);
		wr(IDX_B_ON_CTRL, 16'h2102);
		chk("reg_b_lowpower", 1, reg_b_lowpower);
		chk("reg_b_lp_min_quiescent", 0, reg_b_lp_min_quiescent);
		wr(IDX_B_CTRL, 16'h0001);
		chk("reg_b_lowpower", 1, reg_b_lowpower);
		chk("reg_b_lp_min_quiescent", 1, reg_b_lp_min_quiescent);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{hw_enable_1, hw_enable_2, reg_b_undervolt, sleep_entry, sleep_timeslot} = '0;
		ce = 1'b1;
		err_count = 0;
		compares = 0;
		cycles = 0;
		resets_seen = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_volt();
		t_slot();
		t_hw_a();
		t_uv();
		t_hw_b();
		results();
	end

endmodule

`default_nettype wire
